// ---- src/smf_mode_fraction.sv ----
// mode control and fraction extension word decode for the synthesizer
// Function
// - polarity bit: 0 negative, 1 positive
// - buffer enable: output pin released or copies reference
// - doubler off: both counters get plain reference
// - doubler on: RF counter doubled, IF plain
// - order field: 0 fourth,1 off,2 second,3 third
// - dither: 0 none,1 weak,2 strong,3 reserved
// - auto power-up: frequency write clears both power-downs
// - chip enable low suppresses auto power-up
// - narrow mode: numerator 12 bits, extension ignored
// - wide mode: numerator is extension over low bits
// - narrow mode: denominator 12 bits, extension ignored
// - wide mode: denominator is extension over low bits
// - extension word: denominator 23:14, numerator 13:4
`timescale 1ns/1ps
`default_nettype none
module smf_mode_fraction #(
	parameter int WORD_BITS = 24
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wordValid,
	input wire logic [smf_pkg::WORD_W-1:0] wordData,
	input wire logic mainWordWrite,
	input wire logic pdWrite,
	input wire logic pdRfValue,
	input wire logic pdIfValue,
	input wire logic chipEnablePin,
	input wire logic extAccessEn,
	input wire logic [smf_pkg::FRAC_LOW_W-1:0] fracNumLow,
	input wire logic [smf_pkg::FRAC_LOW_W-1:0] fracDenLow,
	input wire logic refInputPin,
	output logic refOutputPin,
	output logic refOutputOe,
	output logic ifPumpPolarity,
	output logic rfRefDoubled,
	output logic ifRefDoubled,
	output smf_pkg::smf_mod_t modMode,
	output smf_pkg::smf_dither_t ditherMode,
	output logic ditherReserved,
	output logic autoPowerUp,
	output logic rfLoopPowerDown,
	output logic ifLoopPowerDown,
	output logic [smf_pkg::FRAC_W-1:0] fracNumerator,
	output logic [smf_pkg::FRAC_W-1:0] fracDenominator
);
	import smf_pkg::*;

	// the word latch upstream is fixed at the documented word size
	if (WORD_BITS != WORD_W) begin : g_bad_width
		$error("smf_mode_fraction supports only 24-bit words");
	end

	typedef struct packed {
		logic [2:0] ceSync;
		logic ceLevel;
		logic autoPowerUp;
		logic [1:0] ditherSel;
		logic [1:0] orderSel;
		logic doublerEn;
		logic refBufEn;
		logic ifPolarity;
		logic [FRAC_EXT_W-1:0] denExt;
		logic [FRAC_EXT_W-1:0] numExt;
		logic rfPd;
		logic ifPd;
		logic [FRAC_W-1:0] num;
		logic [FRAC_W-1:0] den;
	} smf_main_st_t;

	smf_main_st_t st_ff;
	smf_main_st_t nxt_st;
	smf_cfg_if cfgBus ();

	// joins the fixed extension above the low bits, or drops it when narrow
	function automatic logic [FRAC_W-1:0] frac_join(
		input logic wide,
		input logic [FRAC_EXT_W-1:0] ext,
		input logic [FRAC_LOW_W-1:0] low
	);
		frac_join = {(wide ? ext : {FRAC_EXT_W{1'b0}}), low};
	endfunction : frac_join

	logic modeHit;
	logic extHit;
	assign modeHit = wordValid && wordData[ADDR_W-1:0] == MODE_WORD_ADDR;
	assign extHit = wordValid && wordData[ADDR_W-1:0] == EXT_WORD_ADDR;

	// next state: word loads, chip-enable filter, power-down bits, fractions
	always_comb begin
		nxt_st = st_ff;
		// three-stage pin sync; level moves only when stages 2 and 3 agree
		nxt_st.ceSync = {st_ff.ceSync[1:0], chipEnablePin};
		if (st_ff.ceSync[1] == st_ff.ceSync[2]) begin
			nxt_st.ceLevel = st_ff.ceSync[2];
		end
		if (modeHit) begin
			nxt_st.autoPowerUp = wordData[AUTO_PU_BIT];
			nxt_st.ditherSel = wordData[DITHER_LSB +: 2];
			nxt_st.orderSel = wordData[ORDER_LSB +: 2];
			nxt_st.doublerEn = wordData[DOUBLER_BIT];
			nxt_st.refBufEn = wordData[REF_BUF_BIT];
			nxt_st.ifPolarity = wordData[IF_POL_BIT];
		end
		if (extHit) begin
			nxt_st.denExt = wordData[DEN_EXT_LSB +: FRAC_EXT_W];
			nxt_st.numExt = wordData[NUM_EXT_LSB +: FRAC_EXT_W];
		end
		// a frequency write powers both loops up when auto power-up is set, unless chip enable is low
		if (mainWordWrite && st_ff.autoPowerUp && st_ff.ceLevel) begin
			nxt_st.rfPd = 1'b0;
			nxt_st.ifPd = 1'b0;
		end
		// an explicit power-down write in the same cycle is the newer intent
		if (pdWrite) begin
			nxt_st.rfPd = pdRfValue;
			nxt_st.ifPd = pdIfValue;
		end
		nxt_st.num = frac_join(extAccessEn, st_ff.numExt, fracNumLow);
		nxt_st.den = frac_join(extAccessEn, st_ff.denExt, fracDenLow);
	end

	// registers; the sync stages reset to zero, never to the pin level
	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff.ceSync <= 3'h0;
			st_ff.ceLevel <= 1'b0;
			st_ff.autoPowerUp <= RST_AUTO_PU;
			st_ff.ditherSel <= RST_DITHER;
			st_ff.orderSel <= RST_ORDER;
			st_ff.doublerEn <= RST_DOUBLER;
			st_ff.refBufEn <= RST_REF_BUF;
			st_ff.ifPolarity <= RST_IF_POL;
			st_ff.denExt <= RST_FRAC_EXT;
			st_ff.numExt <= RST_FRAC_EXT;
			st_ff.rfPd <= RST_POWER_DOWN;
			st_ff.ifPd <= RST_POWER_DOWN;
			st_ff.num <= {FRAC_W{1'b0}};
			st_ff.den <= {FRAC_W{1'b0}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// mode fields go out to the decoder and come back as one-hot settings
	assign cfgBus.orderSel = st_ff.orderSel;
	assign cfgBus.ditherSel = st_ff.ditherSel;
	smf_order_decode u_decode (
		.clk(clk),
		.srst(srst),
		.cfg(cfgBus)
	);
	assign modMode = cfgBus.modMode;
	assign ditherMode = cfgBus.ditherMode;
	assign ditherReserved = cfgBus.ditherReserved;

	// reference buffer is a gated path: a copy of the pin, not resampled
	assign refOutputOe = st_ff.refBufEn;
	assign refOutputPin = st_ff.refBufEn & refInputPin;
	// the IF reference counter never sees the doubled clock
	assign rfRefDoubled = st_ff.doublerEn;
	assign ifRefDoubled = 1'b0;
	assign ifPumpPolarity = st_ff.ifPolarity;
	assign autoPowerUp = st_ff.autoPowerUp;
	assign rfLoopPowerDown = st_ff.rfPd;
	assign ifLoopPowerDown = st_ff.ifPd;
	assign fracNumerator = st_ff.num;
	assign fracDenominator = st_ff.den;

	default clocking dcb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_mode_write;
		modeHit;
	endsequence
	sequence s_armed_freq_write;
		autoPowerUp && st_ff.ceLevel ##0 mainWordWrite && !pdWrite;
	endsequence

	chk_if_polarity: assert property (
		s_mode_write |=> ifPumpPolarity == $past(wordData[IF_POL_BIT]))
		else $error("pump polarity did not follow the mode word");
	chk_ref_buffer: assert property (
		s_mode_write |=> refOutputOe == $past(wordData[REF_BUF_BIT])
		&& (refOutputOe || !refOutputPin))
		else $error("reference output driven while disabled");
	chk_doubler_path: assert property (
		s_mode_write |=> rfRefDoubled == $past(wordData[DOUBLER_BIT])
		&& !ifRefDoubled)
		else $error("doubler select wrong or IF path doubled");
	chk_auto_powerup: assert property (
		s_armed_freq_write |=> !rfLoopPowerDown && !ifLoopPowerDown)
		else $error("frequency write did not power up both loops");
	chk_ce_blocks_pu: assert property (
		mainWordWrite && !pdWrite && !st_ff.ceLevel
		|=> $stable(rfLoopPowerDown) && $stable(ifLoopPowerDown))
		else $error("power-down changed with chip enable low");
	chk_num_narrow: assert property (
		!extAccessEn |=> fracNumerator == {10'h000, $past(fracNumLow)})
		else $error("narrow numerator not 12 bits");
	chk_den_wide: assert property (
		extAccessEn && extHit ##1 extAccessEn |=> fracDenominator[21:12]
		== $past(wordData[23:14], 2))
		else $error("wide denominator extension misplaced");
	chk_den_narrow: assert property (
		!extAccessEn |=> fracDenominator <= 22'h000FFF)
		else $error("narrow denominator above 4095");
	chk_ext_hold: assert property (
		wordValid && !extHit |=> $stable(st_ff.numExt)
		&& $stable(st_ff.denExt))
		else $error("extension changed by a foreign word");
endmodule : smf_mode_fraction
`default_nettype wire

// ---- src/smf_pkg.sv ----
// package: mode/fraction word layout, reset values and decoded types
package smf_pkg;
	// word geometry
	localparam int WORD_W = 24;
	localparam int ADDR_W = 4;
	localparam int FRAC_LOW_W = 12;
	localparam int FRAC_EXT_W = 10;
	localparam int FRAC_W = FRAC_LOW_W + FRAC_EXT_W;
	// address codes held in word bits 3..0
	localparam logic [3:0] MODE_WORD_ADDR = 4'h9;
	localparam logic [3:0] EXT_WORD_ADDR = 4'hB;
	// mode control word field positions
	localparam int AUTO_PU_BIT = 23;
	localparam int DITHER_LSB = 16;
	localparam int ORDER_LSB = 14;
	localparam int DOUBLER_BIT = 12;
	localparam int REF_BUF_BIT = 11;
	localparam int IF_POL_BIT = 10;
	// extension word field positions
	localparam int DEN_EXT_LSB = 14;
	localparam int NUM_EXT_LSB = 4;
	// values after reset
	localparam logic RST_AUTO_PU = 1'b0;
	localparam logic [1:0] RST_DITHER = 2'h2;
	localparam logic [1:0] RST_ORDER = 2'h3;
	localparam logic RST_DOUBLER = 1'b0;
	localparam logic RST_REF_BUF = 1'b0;
	localparam logic RST_IF_POL = 1'b1;
	localparam logic [9:0] RST_FRAC_EXT = 10'h000;
	localparam logic RST_POWER_DOWN = 1'b0;
	// field codes
	localparam logic IF_POL_NEGATIVE = 1'b0;
	localparam logic IF_POL_POSITIVE = 1'b1;
	localparam logic [1:0] ORDER_FOURTH = 2'h0;
	localparam logic [1:0] ORDER_OFF = 2'h1;
	localparam logic [1:0] ORDER_SECOND = 2'h2;
	localparam logic [1:0] ORDER_THIRD = 2'h3;
	localparam logic [1:0] DITHER_NONE = 2'h0;
	localparam logic [1:0] DITHER_WEAK = 2'h1;
	localparam logic [1:0] DITHER_STRONG = 2'h2;
	localparam logic [1:0] DITHER_RSVD = 2'h3;
	// decoded modulator setting, one-hot
	typedef enum logic [3:0] {
		SMF_MOD_OFF = 4'h1,
		SMF_MOD_2ND = 4'h2,
		SMF_MOD_3RD = 4'h4,
		SMF_MOD_4TH = 4'h8
	} smf_mod_t;
	// decoded dither setting, one-hot
	typedef enum logic [2:0] {
		SMF_DITHER_OFF = 3'h1,
		SMF_DITHER_WEAK = 3'h2,
		SMF_DITHER_STRONG = 3'h4
	} smf_dither_t;
endpackage : smf_pkg

// ---- src/smf_cfg_if.sv ----
// interface: raw mode fields out to the decoder, decoded settings back
`timescale 1ns/1ps
`default_nettype none
interface smf_cfg_if;
	import smf_pkg::*;
	logic [1:0] orderSel;
	logic [1:0] ditherSel;
	smf_mod_t modMode;
	smf_dither_t ditherMode;
	logic ditherReserved;
	modport cfg (output orderSel, output ditherSel, input modMode,
		input ditherMode, input ditherReserved);
	modport dec (input orderSel, input ditherSel, output modMode,
		output ditherMode, output ditherReserved);
endinterface : smf_cfg_if
`default_nettype wire

// ---- src/smf_order_decode.sv ----
// modulator order and dither field decoder, registered outputs
`timescale 1ns/1ps
`default_nettype none
module smf_order_decode (
	input wire logic clk,
	input wire logic srst,
	smf_cfg_if.dec cfg
);
	import smf_pkg::*;

	typedef struct packed {
		smf_mod_t modMode;
		smf_dither_t ditherMode;
		logic ditherReserved;
	} smf_dec_st_t;

	smf_dec_st_t st_ff;
	smf_dec_st_t nxt_st;

	// field codes to one-hot settings; reserved dither falls back to off
	always_comb begin
		nxt_st = st_ff;
		unique case (cfg.orderSel)
			ORDER_FOURTH: nxt_st.modMode = SMF_MOD_4TH;
			ORDER_OFF: nxt_st.modMode = SMF_MOD_OFF;
			ORDER_SECOND: nxt_st.modMode = SMF_MOD_2ND;
			ORDER_THIRD: nxt_st.modMode = SMF_MOD_3RD;
		endcase
		nxt_st.ditherReserved = (cfg.ditherSel == DITHER_RSVD);
		unique case (cfg.ditherSel)
			DITHER_WEAK: nxt_st.ditherMode = SMF_DITHER_WEAK;
			DITHER_STRONG: nxt_st.ditherMode = SMF_DITHER_STRONG;
			DITHER_NONE, DITHER_RSVD: nxt_st.ditherMode = SMF_DITHER_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_ff.modMode <= SMF_MOD_3RD;
			st_ff.ditherMode <= SMF_DITHER_STRONG;
			st_ff.ditherReserved <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cfg.modMode = st_ff.modMode;
	assign cfg.ditherMode = st_ff.ditherMode;
	assign cfg.ditherReserved = st_ff.ditherReserved;

	default clocking dcb @(posedge clk); endclocking
	default disable iff (srst);

	chk_order_map: assert property (
		cfg.orderSel == ORDER_OFF |=> cfg.modMode == SMF_MOD_OFF)
		else $error("order code 1 did not disable the modulator");
	chk_order_fourth: assert property (
		cfg.orderSel == ORDER_FOURTH ##1 cfg.orderSel == ORDER_SECOND
		|=> cfg.modMode == SMF_MOD_2ND && $past(cfg.modMode) == SMF_MOD_4TH)
		else $error("order codes 0 and 2 decoded wrongly");
	chk_dither_map: assert property (
		cfg.ditherSel[1] |=> cfg.ditherMode != SMF_DITHER_WEAK
		&& cfg.ditherReserved == (cfg.ditherMode == SMF_DITHER_OFF))
		else $error("dither code 2 or 3 decoded wrongly");
endmodule : smf_order_decode
`default_nettype wire

// ---- testbench/smf_host_model.sv ----
// host model: writes complete words towards the decode block
`timescale 1ns/1ps
`default_nettype none
module smf_host_model (
	input wire logic clk,
	output logic wordValid,
	output logic [23:0] wordData
);
	initial begin
		wordValid = 1'b0;
		wordData = 24'h000000;
	end
	// one-cycle word strobe, then the bus shows the inverse
	// so a stale word never looks valid to the decoder
	// order code 1 is sent only by test sequences
	// dither code 3 is never handed to this task
	task send(input logic [23:0] w);
		@(posedge clk);
		#2;
		wordValid = 1'b1;
		wordData = w;
		@(posedge clk);
		#2;
		wordValid = 1'b0;
		wordData = ~w;
	endtask : send
endmodule : smf_host_model
`default_nettype wire

// ---- testbench/synth_mode_fraction_tb_top.sv ----
// testbench: mode word decode, fraction widths and auto power-up
`timescale 1ns/1ps
`default_nettype none
module synth_mode_fraction_tb_top;
	import smf_pkg::*;
	logic clk = 1'b0, srst = 1'b1, wordValid, refInputPin = 1'b0;
	logic mainWordWrite = 1'b0, pdWrite = 1'b0, chipEnablePin = 1'b1;
	logic pdRfValue = 1'b1, pdIfValue = 1'b1, extAccessEn = 1'b0;
	logic [23:0] wordData;
	// denominator stays above 1000 whenever dithering is on
	logic [11:0] fracNumLow = 12'hFFF, fracDenLow = 12'hFFF;
	logic refOutputPin, refOutputOe, ifPumpPolarity, rfRefDoubled;
	logic ifRefDoubled, ditherReserved, autoPowerUp;
	logic rfLoopPowerDown, ifLoopPowerDown;
	logic [21:0] fracNumerator, fracDenominator;
	smf_mod_t modMode;
	smf_dither_t ditherMode;
	smf_mod_t modExp [4] = '{SMF_MOD_4TH, SMF_MOD_OFF, SMF_MOD_2ND,
		SMF_MOD_3RD};
	smf_dither_t ditherExp [3] = '{SMF_DITHER_OFF, SMF_DITHER_WEAK,
		SMF_DITHER_STRONG};
	int err_count = 0, checks_done = 0, cycles = 0;
	smf_host_model host (.clk(clk), .wordValid(wordValid),
		.wordData(wordData));
	smf_mode_fraction #(.WORD_BITS(24)) uut (.clk(clk), .srst(srst),
		.wordValid(wordValid), .wordData(wordData),
		.mainWordWrite(mainWordWrite), .pdWrite(pdWrite),
		.pdRfValue(pdRfValue), .pdIfValue(pdIfValue),
		.chipEnablePin(chipEnablePin), .extAccessEn(extAccessEn),
		.fracNumLow(fracNumLow), .fracDenLow(fracDenLow),
		.refInputPin(refInputPin), .refOutputPin(refOutputPin),
		.refOutputOe(refOutputOe), .ifPumpPolarity(ifPumpPolarity),
		.rfRefDoubled(rfRefDoubled), .ifRefDoubled(ifRefDoubled),
		.modMode(modMode), .ditherMode(ditherMode),
		.ditherReserved(ditherReserved), .autoPowerUp(autoPowerUp),
		.rfLoopPowerDown(rfLoopPowerDown),
		.ifLoopPowerDown(ifLoopPowerDown),
		.fracNumerator(fracNumerator), .fracDenominator(fracDenominator));
	// clock and a toggling reference so the buffer path is exercised
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		#2 refInputPin <= ~refInputPin;
	end
	// hang guard: the whole sequence needs well under 400 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	task check(string name, logic [23:0] seen, logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task end_of_test;
		$display("mismatches %0d comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task cyc(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	function automatic logic [23:0] modeWord(logic apu, logic [1:0] dither_sel,
		logic [1:0] ord, logic dbl, logic buff, logic pol);
		logic [23:0] w;
		w = 24'h000000;
		w[AUTO_PU_BIT] = apu;
		w[DITHER_LSB+:2] = dither_sel;
		w[ORDER_LSB+:2] = ord;
		w[DOUBLER_BIT] = dbl;
		w[REF_BUF_BIT] = buff;
		w[IF_POL_BIT] = pol;
		w[3:0] = MODE_WORD_ADDR;
		return w;
	endfunction : modeWord
	// force both loops down, then try a frequency-word power-up
	task pwr(logic ce, logic exp);
		chipEnablePin = ce;
		pdWrite = 1'b1;
		cyc(6);
		pdWrite = 1'b0;
		mainWordWrite = 1'b1;
		cyc(1);
		mainWordWrite = 1'b0;
		cyc(2);
		check("rfDown", rfLoopPowerDown, exp);
		check("ifDown", ifLoopPowerDown, exp);
	endtask : pwr
	initial begin
		int d;
		cyc(6);
		srst = 1'b0;
		cyc(6);
		check("rstPol", ifPumpPolarity, 1);
		check("rstMod", modMode, SMF_MOD_3RD);
		check("rstDither", ditherMode, SMF_DITHER_STRONG);
		check("rstDown", {rfLoopPowerDown, ifLoopPowerDown}, 0);
		// every order code, visited 0,2,1,3 so code 0 is followed by 2
		for (int i = 0; i < 4; i++) begin
			d = i % 3;
			host.send(modeWord(i[0], 2'(d), {i[0], i[1]}, i[0], i[1], i[0]));
			cyc(3);
			check("polarity", ifPumpPolarity, i[0]);
			check("rfDoubled", rfRefDoubled, i[0]);
			check("ifDoubled", ifRefDoubled, 0);
			check("bufOe", refOutputOe, i[1]);
			check("refOut", refOutputPin, refInputPin & i[1]);
			check("modMode", modMode, modExp[{i[0], i[1]}]);
			check("dither", ditherMode, ditherExp[d]);
			check("ditherRsvd", ditherReserved, 0);
			check("autoPu", autoPowerUp, i[0]);
		end
		// wrong address code must leave every field alone
		host.send(modeWord(0, 2'h2, 2'h0, 0, 0, 0) ^ 24'h00000C);
		cyc(3);
		check("keepPol", ifPumpPolarity, 1);
		check("keepMod", modMode, SMF_MOD_3RD);
		check("keepPu", autoPowerUp, 1);
		pwr(1'b1, 1'b0);
		pwr(1'b0, 1'b1);
		host.send(modeWord(0, 2'h0, 2'h3, 0, 0, 1));
		pwr(1'b1, 1'b1);
		// extension word: denominator bits 23:14, numerator 13:4
		host.send({10'h001, 10'h3FF, EXT_WORD_ADDR});
		cyc(3);
		check("narrowNum", fracNumerator, 22'h000FFF);
		check("narrowDen", fracDenominator, 22'h000FFF);
		check("extKeepMod", modMode, SMF_MOD_3RD);
		extAccessEn = 1'b1;
		cyc(3);
		check("wideNum", fracNumerator, 22'h3FFFFF);
		check("wideDen", fracDenominator, 22'h001FFF);
		// a second extension word while wide mode is already selected
		host.send({10'h2AA, 10'h155, EXT_WORD_ADDR});
		cyc(3);
		check("wideNum2", fracNumerator, 22'h155FFF);
		check("wideDen2", fracDenominator, 22'h2AAFFF);
		end_of_test();
	end
endmodule : synth_mode_fraction_tb_top
`default_nettype wire
